// ==== hnu_baud.sv ====
`timescale 1ns/10ps
// eight-times-baud state tick generator
module hnu_baud (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic [2:0] baud_select,
	output logic            state_tick
);
	typedef struct packed {
		logic [9:0] cnt;
		logic       tick;
	} hnu_baud_st_type;

	hnu_baud_st_type r_reg;
	hnu_baud_st_type r_next;
	logic [12:0]     div;
	logic [9:0]      last;

	// divisor over eight gives cycles per state
	assign div  = hnu_pkg::BAUD_DIV[baud_select];
	assign last = 10'((div >> hnu_pkg::STATES_LOG2) - 13'h0001);

	// compare against the live limit so a new code acts at once
	always_comb begin
		r_next      = r_reg;
		r_next.tick = 1'b0;
		if (r_reg.cnt >= last) begin
			r_next.cnt  = '0;
			r_next.tick = 1'b1;
		end else begin
			r_next.cnt = r_reg.cnt + 10'h001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign state_tick = r_reg.tick;
endmodule : hnu_baud

// ==== hnu_pkg.sv ====
// Function
// - while idle and not sending, watch receive input for a falling edge
// - after the edge, wait one bit time of eight states for the start bit
// - received ninth bit overwrites the ninth-bit field set for sending
// - after nine bits, wait the stop bit, then move character to buffer
// - receive-full set on transfer; receive interrupt asked if enabled
// - a transmit start aborts any reception in progress
// - each interrupt asked only when its own enable bit is set
// - data write loads shifter, starts sending, clears transmit-done
// - data read returns the receive buffer, not transmit data
// - three-bit baud field selects the clock divisor; code 111 reserved
// - baud change acts at once; software avoids changing it mid-character
// - receive-full cleared by writing zero, set by writing one
// - transmit-done set after a character; cleared by zero or data write
// - writing interrupt enables also loads both status flags from the same written byte
// - ninth bit: write sets sent level, read gives last received one
// - send zero start, eight data bits lsb first, ninth bit, one stop
// - receiver at eight times baud, two-of-three vote per bit
// - with no transmission, transmit pin follows ordinary port value
package hnu_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_DATA = 8'hd6;
	localparam logic [7:0] IDX_CTRL = 8'hd7;
	localparam int         ADR_W    = 10;
	localparam logic [ADR_W-1:0] ADR_DATA = ADR_W'({IDX_DATA, 2'b00});
	localparam logic [ADR_W-1:0] ADR_CTRL = ADR_W'({IDX_CTRL, 2'b00});

	// control register fields
	localparam int CTL_RXF   = 7;
	localparam int CTL_TXD   = 6;
	localparam int CTL_RXIE  = 5;
	localparam int CTL_TXIE  = 4;
	localparam int CTL_BR_HI = 3;
	localparam int CTL_BR_LO = 1;
	localparam int CTL_NINTH = 0;

	// reset values
	localparam logic [2:0] BAUD_RST = 3'h0;
	localparam logic [7:0] BUF_RST  = 8'h00;

	// timing: states per bit and voting sample points
	localparam int         STATES_LOG2 = 3;
	localparam logic [2:0] LAST_STATE  = 3'h7;
	localparam logic [2:0] SAMPLE_A    = 3'h2;
	localparam logic [2:0] SAMPLE_C    = 3'h4;
	localparam logic [3:0] RX_BITS     = 4'h9;
	localparam logic [3:0] TX_LAST     = 4'ha;

	// internal clock divisors per baud code; code 7 reserved, runs as 6
	localparam logic [12:0] BAUD_DIV [8] = '{
		13'h1a00, 13'h0d00, 13'h0680, 13'h0340,
		13'h01a0, 13'h0100, 13'h00d0, 13'h00d0
	};

	typedef enum logic [1:0] {
		RX_IDLE,
		RX_START,
		RX_DATA,
		RX_STOP
	} hnu_rx_state_type;
endpackage : hnu_pkg

// ==== hnu_remote_node.sv ====
`timescale 1ns/10ps
// far-end node: sends frames on the line, captures what it hears
module hnu_remote_node (
	input  wire logic sys_clk,
	input  wire logic line_in,
	output logic      line_out
);
	logic [8:0] rx_word = 9'h000;
	initial line_out = 1'b1;
	// start low, nine bits lsb first, stop high; line rests high
	task automatic send(input logic [8:0] d, input int bt);
		line_out <= 1'b0;
		repeat (bt) @(posedge sys_clk);
		for (int i = 0; i < 9; i++) begin
			line_out <= d[i];
			repeat (bt) @(posedge sys_clk);
		end
		line_out <= 1'b1;
		repeat (bt) @(posedge sys_clk);
	endtask : send
	// mid-bit sampling at the fastest rate only; other rates give junk
	always begin
		@(negedge line_in);
		repeat (312) @(posedge sys_clk);
		for (int i = 0; i < 9; i++) begin
			rx_word[i] = line_in;
			repeat (208) @(posedge sys_clk);
		end
	end
endmodule : hnu_remote_node

// ==== hnu_uart.sv ====
`timescale 1ns/10ps
// half-duplex nine-bit serial port with wishbone register access
module hnu_uart (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [9:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        rx_pin,
	input  wire logic        port_out_value,
	output logic             tx_pin,
	output logic             serial_output_select,
	output logic             rx_irq,
	output logic             tx_irq
);
	typedef struct packed {
		logic                      ack;
		logic [7:0]                dat;
		logic                      s1;
		logic                      s2;
		logic                      s3;
		logic                      lvl;
		hnu_pkg::hnu_rx_state_type rx_st;
		logic [2:0]                rx_sub;
		logic [3:0]                rx_cnt;
		logic [1:0]                votes;
		logic [8:0]                rx_sh;
		logic [7:0]                rx_buf;
		logic                      ninth;
		logic                      rx_full;
		logic                      tx_done;
		logic                      rx_ie;
		logic                      tx_ie;
		logic [2:0]                baud;
		logic                      tx_act;
		logic [10:0]               tx_sh;
		logic [2:0]                tx_sub;
		logic [3:0]                tx_cnt;
		logic                      txp;
		logic                      rxi;
		logic                      txi;
	} hnu_uart_st_type;

	hnu_uart_st_type r_reg;
	hnu_uart_st_type r_next;
	logic            tick;
	logic            acc;
	logic            wr_data;
	logic            wr_ctrl;
	logic            fell;
	logic            tx_fin;
	logic            rx_fin;
	logic            bit_val;
	logic [7:0]      ctrl_rd;

	hnu_baud u_baud (
		.sys_clk     (sys_clk),
		.rst         (rst),
		.baud_select (r_reg.baud),
		.state_tick  (tick)
	);

	// a request is answered one cycle after it appears
	assign acc     = wb_cyc_i & wb_stb_i & ~r_reg.ack;
	assign wr_data = acc & wb_we_i & wb_sel_i[0] & (wb_adr_i == hnu_pkg::ADR_DATA);
	assign wr_ctrl = acc & wb_we_i & wb_sel_i[0] & (wb_adr_i == hnu_pkg::ADR_CTRL);

	// filtered level changes only when the last two stages agree
	assign fell = r_reg.lvl & (r_reg.s2 == r_reg.s3) & ~r_reg.s3;

	// majority of three: two set votes, or one plus a set last sample
	assign bit_val = r_reg.votes[1] | (r_reg.votes[0] & r_reg.lvl);

	// control readback
	assign ctrl_rd = {r_reg.rx_full, r_reg.tx_done, r_reg.rx_ie, r_reg.tx_ie,
		r_reg.baud, r_reg.ninth};

	always_comb begin
		r_next     = r_reg;
		tx_fin     = 1'b0;
		rx_fin     = 1'b0;

		// bus answer; unmapped reads give zero, unmapped writes are dropped
		r_next.ack = acc;
		r_next.dat = '0;
		if (acc & ~wb_we_i) begin
			if (wb_adr_i == hnu_pkg::ADR_DATA) begin
				r_next.dat = r_reg.rx_buf;
			end else if (wb_adr_i == hnu_pkg::ADR_CTRL) begin
				r_next.dat = ctrl_rd;
			end
		end

		// three-stage input synchroniser with agreement filter
		r_next.s1 = rx_pin;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		if (r_reg.s2 == r_reg.s3) begin
			r_next.lvl = r_reg.s3;
		end

		// control write; enables and flags are separate fields
		if (wr_ctrl) begin
			r_next.rx_full = wb_dat_i[hnu_pkg::CTL_RXF];
			r_next.tx_done = wb_dat_i[hnu_pkg::CTL_TXD];
			r_next.rx_ie   = wb_dat_i[hnu_pkg::CTL_RXIE];
			r_next.tx_ie   = wb_dat_i[hnu_pkg::CTL_TXIE];
			r_next.baud    = wb_dat_i[hnu_pkg::CTL_BR_HI:hnu_pkg::CTL_BR_LO];
			r_next.ninth   = wb_dat_i[hnu_pkg::CTL_NINTH];
		end

		// transmitter: a data write restarts it even mid-character
		if (wr_data) begin
			r_next.tx_act  = 1'b1;
			r_next.tx_sh   = {1'b1, r_next.ninth, wb_dat_i[7:0], 1'b0};
			r_next.tx_sub  = '0;
			r_next.tx_cnt  = '0;
			r_next.tx_done = 1'b0;
		end else if (r_reg.tx_act & tick) begin
			r_next.tx_sub = r_reg.tx_sub + 3'h1;
			if (r_reg.tx_sub == hnu_pkg::LAST_STATE) begin
				r_next.tx_sh  = {1'b1, r_reg.tx_sh[10:1]};
				r_next.tx_cnt = r_reg.tx_cnt + 4'h1;
				if (r_reg.tx_cnt == hnu_pkg::TX_LAST) begin
					r_next.tx_act = 1'b0;
					tx_fin        = 1'b1;
				end
			end
		end

		// receiver runs only while nothing is being sent
		if (r_next.tx_act) begin
			r_next.rx_st = hnu_pkg::RX_IDLE;
		end else begin
			unique case (r_reg.rx_st)
				hnu_pkg::RX_IDLE: begin
					if (fell) begin
						r_next.rx_st  = hnu_pkg::RX_START;
						r_next.rx_sub = '0;
						r_next.rx_cnt = '0;
						r_next.votes  = '0;
					end
				end
				hnu_pkg::RX_START: begin
					if (tick) begin
						r_next.rx_sub = r_reg.rx_sub + 3'h1;
						if (r_reg.rx_sub == hnu_pkg::LAST_STATE) begin
							r_next.rx_st = hnu_pkg::RX_DATA;
						end
					end
				end
				hnu_pkg::RX_DATA: begin
					if (tick) begin
						r_next.rx_sub = r_reg.rx_sub + 3'h1;
						// count low-level-independent ones in first two samples
						if (r_reg.rx_sub >= hnu_pkg::SAMPLE_A &&
							r_reg.rx_sub < hnu_pkg::SAMPLE_C && r_reg.lvl) begin
							r_next.votes = r_reg.votes + 2'h1;
						end
						if (r_reg.rx_sub == hnu_pkg::SAMPLE_C) begin
							r_next.rx_sh = {bit_val, r_reg.rx_sh[8:1]};
							r_next.votes = '0;
							r_next.rx_cnt = r_reg.rx_cnt + 4'h1;
						end
						if (r_reg.rx_sub == hnu_pkg::LAST_STATE &&
							r_reg.rx_cnt == hnu_pkg::RX_BITS) begin
							r_next.rx_st = hnu_pkg::RX_STOP;
							r_next.ninth = r_reg.rx_sh[8];
						end
					end
				end
				hnu_pkg::RX_STOP: begin
					if (tick) begin
						r_next.rx_sub = r_reg.rx_sub + 3'h1;
						if (r_reg.rx_sub == hnu_pkg::LAST_STATE) begin
							r_next.rx_st  = hnu_pkg::RX_IDLE;
							r_next.rx_buf = r_reg.rx_sh[7:0];
							rx_fin        = 1'b1;
						end
					end
				end
			endcase
		end

		// hardware sets win over software clears in the same cycle
		if (rx_fin) begin
			r_next.rx_full = 1'b1;
		end
		if (tx_fin) begin
			r_next.tx_done = 1'b1;
		end

		// pin mux: port value whenever the shifter is not driving
		r_next.txp = r_next.tx_act ? r_next.tx_sh[0] : port_out_value;

		// each request gated by its own enable
		r_next.rxi = r_next.rx_full & r_next.rx_ie;
		r_next.txi = r_next.tx_done & r_next.tx_ie;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			r_reg        <= '0;
			r_reg.s1     <= 1'b1;
			r_reg.s2     <= 1'b1;
			r_reg.s3     <= 1'b1;
			r_reg.lvl    <= 1'b1;
			r_reg.rx_st  <= hnu_pkg::RX_IDLE;
			r_reg.baud   <= hnu_pkg::BAUD_RST;
			r_reg.rx_buf <= hnu_pkg::BUF_RST;
			r_reg.txp    <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign wb_dat_o             = {24'h00_0000, r_reg.dat};
	assign wb_ack_o             = r_reg.ack;
	assign tx_pin               = r_reg.txp;
	assign serial_output_select = r_reg.tx_act;
	assign rx_irq               = r_reg.rxi;
	assign tx_irq               = r_reg.txi;
endmodule : hnu_uart

// ==== hnu_uart_assertions.sv ====
`timescale 1ns/10ps
// pin-level checks for the serial port
module hnu_uart_chk (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [9:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        port_out_value,
	input wire logic        tx_pin,
	input wire logic        serial_output_select,
	input wire logic        rx_irq
);
	logic        take, data_wr, ctrl_wr;
	logic [16:0] len_reg, len_next;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// request decode, as the slave takes a cycle
	assign take    = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign data_wr = take && wb_we_i && wb_sel_i[0] && wb_adr_i == hnu_pkg::ADR_DATA;
	assign ctrl_wr = take && wb_we_i && wb_sel_i[0] && wb_adr_i == hnu_pkg::ADR_CTRL;
	// cycles spent sending; saturates so a stuck select cannot wrap
	always_comb begin
		len_next = serial_output_select ? len_reg + 17'h0_0001 : 17'h0_0000;
		if (&len_reg && serial_output_select)
			len_next = len_reg;
	end
	always_ff @(posedge sys_clk) begin
		len_reg <= rst ? 17'h0_0000 : len_next;
	end
	chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	chk_ack_next: assert property (take |=> wb_ack_o)
		else $error("request not answered next cycle");
	chk_read_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside ack");
	chk_tx_start: assert property (data_wr |=> serial_output_select && !tx_pin)
		else $error("data write did not start a start bit");
	chk_idle_pin: assert property (!serial_output_select && !$past(serial_output_select)
		&& !$past(rst) |-> tx_pin == $past(port_out_value))
		else $error("idle pin not following port value");
	chk_stop_high: assert property ($fell(serial_output_select) |-> $past(tx_pin))
		else $error("stop bit not high");
	chk_frame_len: assert property ($fell(serial_output_select) |-> len_reg >= 17'h0_08d0)
		else $error("frame shorter than eleven bits");
	chk_rx_clear: assert property ($fell(rx_irq) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
		else $error("receive request dropped without control write");
endmodule : hnu_uart_chk

bind hnu_uart hnu_uart_chk hnu_uart_chk_i (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .port_out_value, .tx_pin,
	.serial_output_select, .rx_irq);

// ==== hnu_uart_tb_top.sv ====
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
	$display("unexpected at %0t got %h expected %h", $time, g, e); end end
// bench for the nine-bit serial port
module hnu_uart_tb_top;
	logic        sys_clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [9:0]  adr = 10'h000;
	logic [31:0] dat_i = 32'h0000_0000, dat_o;
	logic        ack, rx_pin, port_val = 1'b1, tx_pin, sel_o, rx_irq, tx_irq;
	logic [7:0]  q;
	int          bad_count = 0, n_compared = 0, n;
	int          dv [8] = '{6656, 3328, 1664, 832, 416, 256, 208, 208};
	always #20 sys_clk = ~sys_clk;
	hnu_uart hnu_uart_i (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat_i), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .rx_pin(rx_pin), .port_out_value(port_val), .tx_pin(tx_pin),
		.serial_output_select(sel_o), .rx_irq(rx_irq), .tx_irq(tx_irq));
	hnu_remote_node hnu_remote_node_i (.sys_clk(sys_clk), .line_in(tx_pin), .line_out(rx_pin));
	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	// one classic cycle; the data register is only ever read or written whole
	task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_i <= {24'h00_0000, d};
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = dat_o[7:0];
		bad_count += (n >= 20);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus
	task automatic wait_hi(ref logic s, input logic lvl, input int lim);
		n = 0;
		while (s !== lvl && n < lim) begin
			@(posedge sys_clk);
			n++;
		end
		bad_count += (n >= lim);
	endtask : wait_hi
	task automatic t_tx;
		bus(1'b0, hnu_pkg::ADR_DATA, 8'h00);
		`CHK(q, 8'h00)
		bus(1'b1, hnu_pkg::ADR_CTRL, 8'h1d);
		bus(1'b1, hnu_pkg::ADR_DATA, 8'ha5);
		wait_hi(tx_irq, 1'b1, 3000);
		`CHK(hnu_remote_node_i.rx_word, 9'h1a5)
		bus(1'b0, hnu_pkg::ADR_CTRL, 8'h00);
		`CHK(q, 8'h5d)
		bus(1'b1, hnu_pkg::ADR_DATA, 8'h3c);
		bus(1'b0, hnu_pkg::ADR_CTRL, 8'h00);
		`CHK(q[6], 1'b0)
		wait_hi(tx_irq, 1'b1, 3000);
		`CHK(hnu_remote_node_i.rx_word, 9'h13c)
		bus(1'b1, hnu_pkg::ADR_CTRL, 8'h0d);
		@(posedge sys_clk);
		`CHK(tx_irq, 1'b0)
	endtask : t_tx
	task automatic t_rx;
		bus(1'b1, hnu_pkg::ADR_CTRL, 8'h2c);
		hnu_remote_node_i.send(9'h13c, 208);
		wait_hi(rx_irq, 1'b1, 1000);
		bus(1'b0, hnu_pkg::ADR_DATA, 8'h00);
		`CHK(q, 8'h3c)
		bus(1'b0, hnu_pkg::ADR_CTRL, 8'h00);
		`CHK(q, 8'had)
		bus(1'b1, hnu_pkg::ADR_CTRL, 8'h2c);
		@(posedge sys_clk);
		`CHK(rx_irq, 1'b0)
		bus(1'b1, hnu_pkg::ADR_CTRL, 8'h8c);
		@(posedge sys_clk);
		`CHK(rx_irq, 1'b0)
		// flag written back as one so only the enable moves
		bus(1'b1, hnu_pkg::ADR_CTRL, 8'hac);
		@(posedge sys_clk);
		`CHK(rx_irq, 1'b1)
		bus(1'b1, hnu_pkg::ADR_CTRL, 8'h0c);
	endtask : t_rx
	// a send launched mid-reception must win
	task automatic t_abort;
		fork
			hnu_remote_node_i.send(9'h155, 208);
			begin
				repeat (800) @(posedge sys_clk);
				bus(1'b1, hnu_pkg::ADR_DATA, 8'h00);
			end
		join
		wait_hi(sel_o, 1'b0, 3000);
		bus(1'b0, hnu_pkg::ADR_CTRL, 8'h00);
		`CHK(q[7], 1'b0)
		bus(1'b0, hnu_pkg::ADR_DATA, 8'h00);
		`CHK(q, 8'h3c)
	endtask : t_abort
	// start bit length per code, then fast rate at once to finish quickly
	task automatic t_baud;
		int start_len;
		for (int c = 0; c < 8; c++) begin
			bus(1'b1, hnu_pkg::ADR_CTRL, {4'h0, 3'(c), 1'b1});
			bus(1'b1, hnu_pkg::ADR_DATA, 8'hff);
			wait_hi(tx_pin, 1'b1, 7000);
			// keep the count; the next bus call reuses n
			start_len = n;
			bus(1'b1, hnu_pkg::ADR_CTRL, 8'h0d);
			`CHK(start_len >= dv[c] - dv[c] / 8 - 2 && start_len <= dv[c], 1'b1)
			wait_hi(sel_o, 1'b0, 3000);
		end
		port_val <= 1'b0;
		repeat (3) @(posedge sys_clk);
		`CHK(tx_pin, 1'b0)
	endtask : t_baud
	initial begin
		repeat (80000) @(posedge sys_clk);
		bad_count++;
		print_verdict();
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		t_tx();
		t_rx();
		t_abort();
		t_baud();
		print_verdict();
	end
endmodule : hnu_uart_tb_top
